// [lpsr_ctrl_model.sv]
// controller model driving the command bus on the falling edge
`timescale 1ns/1ps
module lpsr_ctrl_model
   import lpsr_pkg::*;
#(
   parameter int RL           = 3,
   parameter int DQSCK_CYCLES = 1,
   parameter int BURST_LEN    = 4
) (
   input  wire logic core_clk,
   output logic      cke,
   output logic      cs_n,
   output logic [9:0] ca_rise,
   output logic [9:0] ca_fall
);
   initial
   begin
      cke = 1'b1;
      cs_n = 1'b1;
      ca_rise = 10'h155;
      ca_fall = 10'h2AA;
   end
   // deselect, bus pattern keeps changing
   task automatic nop(input int n);
      repeat (n)
      begin
         @(negedge core_clk);
         cs_n = 1'b1;
         ca_rise = ~ca_rise;
         ca_fall = ~ca_fall;
      end
   endtask
   task automatic send(input logic k, input logic [9:0] r, input logic [9:0] f);
      @(negedge core_clk);
      cke = k;
      cs_n = 1'b0;
      ca_rise = r;
      ca_fall = f;
      nop(1);
   endtask
   task automatic mrr(input logic [7:0] a);
      nop(BURST_LEN / 2);
      send(1'b1, {a[5:0], CMD_MRR}, {8'h00, a[7:6]});
   endtask
   task automatic mrw(input logic [7:0] a, input logic [7:0] d);
      nop(RL + DQSCK_CYCLES + 4 / 2 + 1);
      send(1'b1, {a[5:0], CMD_MRW}, {d, a[7:6]});
   endtask
   task automatic sref();
      send(1'b0, {7'h00, CMD_SREF}, 10'h000);
   endtask
   task automatic wake();
      nop(2);
      @(negedge core_clk);
      cke = 1'b1;
   endtask
   task automatic refresh_all();
      send(1'b1, {7'h00, 3'h4}, 10'h000);
   endtask
endmodule // lpsr_ctrl_model

// [lpsr_device.sv]
// device side: self refresh exit, array masking, mode register read bursts
`timescale 1ns/1ps
module lpsr_device
   import lpsr_pkg::*;
#(
   parameter int RL               = 3,
   parameter int DENSITY_MBIT     = 1024,
   parameter int REF_STEP_CYCLES  = 16,
   parameter int TSI_CYCLES_P     = TSI_CYCLES
) (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        cke,
   input  wire logic        cs_n,
   input  wire logic [9:0]  ca_rise,
   input  wire logic [9:0]  ca_fall,
   input  wire logic [2:0]  sensor_code,
   output logic      [31:0] dq_rise,
   output logic      [31:0] dq_fall,
   output logic             dq_oe,
   output logic             dqs_oe,
   output logic             mrr_ready,
   output logic             self_refresh_active,
   output logic             xsr_busy,
   output logic             refresh_pulse,
   output logic      [2:0]  refresh_bank,
   output logic      [2:0]  refresh_segment
);
   import lpsr_pkg::*;

   localparam int  NUM_BANKS = (DENSITY_MBIT >= SEG_MIN_MBIT) ? 8 : 4;
   localparam bit  SEG_EN    = DENSITY_MBIT >= SEG_MIN_MBIT;
   localparam int  LW        = RL - 1;

   typedef enum logic [1:0] {ST_IDLE, ST_SREF, ST_XSR} lpsr_state_t;

   function automatic logic [31:0] beat_word(input logic [ENTRY_W-1:0] e, input int idx);
      logic [31:0] w;
      w = 32'h0;
      case (lpsr_kind_t'(e[ENTRY_W-1:8]))
         KIND_CAL_A: w = {32{CAL_A_BEATS[idx]}};
         KIND_CAL_B: w = {32{CAL_B_BEATS[idx]}};
         default:    w = (idx == 0) ? {24'h0, e[7:0]} : 32'h0; // RULE15
      endcase
      return w;
   endfunction

   // command decode
   logic       prev_cke_reg;
   logic [3:0] cmd;
   logic [7:0] cmd_addr;
   logic       is_mrr, is_mrw, is_sref;

   assign cmd      = ca_rise[3:0];
   assign cmd_addr = {ca_fall[1:0], ca_rise[9:4]}; // RULE14
   assign is_mrr   = cke && !cs_n && cmd == CMD_MRR; // RULE14
   assign is_mrw   = cke && !cs_n && cmd == CMD_MRW;
   assign is_sref  = prev_cke_reg && !cke && !cs_n && ca_rise[2:0] == CMD_SREF;

   // self refresh state group
   lpsr_state_t state_reg, state_next;
   logic [7:0]  xsr_cnt_reg, xsr_cnt_next;
   logic [7:0]  ckesr_cnt_reg, ckesr_cnt_next;
   logic        sr_out_reg, sr_out_next, xsr_out_reg, xsr_out_next, exit_now;

   always_comb
   begin
      state_next     = state_reg;
      xsr_cnt_next   = xsr_cnt_reg;
      ckesr_cnt_next = ckesr_cnt_reg;
      exit_now       = 1'b0;
      case (state_reg)
         ST_IDLE:
            if (is_sref)
            begin
               state_next     = ST_SREF;
               ckesr_cnt_next = 8'(CKESR_CYCLES);
            end
         ST_SREF:
         begin
            if (ckesr_cnt_reg != 8'h0)
               ckesr_cnt_next = ckesr_cnt_reg - 8'h1; // RULE24
            if (cke && ckesr_cnt_reg == 8'h0)
            begin
               state_next   = ST_XSR; // RULE7
               xsr_cnt_next = 8'(XSR_CYCLES);
               exit_now     = 1'b1;
            end
         end
         ST_XSR:
         begin
            xsr_cnt_next = xsr_cnt_reg - 8'h1; // RULE7
            if (xsr_cnt_reg == 8'h1)
               state_next = ST_IDLE;
         end
         default: state_next = ST_IDLE;
      endcase
      sr_out_next  = state_next == ST_SREF;
      xsr_out_next = state_next == ST_XSR;
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         state_reg     <= ST_IDLE;
         xsr_cnt_reg   <= 8'h0;
         ckesr_cnt_reg <= 8'h0;
         prev_cke_reg  <= 1'b0;
         sr_out_reg    <= 1'b0;
         xsr_out_reg   <= 1'b0;
      end
      else
      begin
         state_reg     <= state_next;
         xsr_cnt_reg   <= xsr_cnt_next;
         ckesr_cnt_reg <= ckesr_cnt_next;
         prev_cke_reg  <= cke;
         sr_out_reg    <= sr_out_next;
         xsr_out_reg   <= xsr_out_next;
      end
   end

   // mask registers
   logic [7:0] bank_mask_reg, bank_mask_next, seg_mask_reg, seg_mask_next;
   logic       cmd_ok;

   assign cmd_ok = state_reg == ST_IDLE;

   always_comb
   begin
      bank_mask_next = bank_mask_reg;
      seg_mask_next  = seg_mask_reg;
      if (is_mrw && cmd_ok && cmd_addr == MA_BANK_MASK)
         bank_mask_next = ca_fall[9:2]; // RULE8
      if (is_mrw && cmd_ok && cmd_addr == MA_SEG_MASK && SEG_EN)
         seg_mask_next = ca_fall[9:2]; // RULE11
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         bank_mask_reg <= MASK_RESET;
         seg_mask_reg  <= MASK_RESET;
      end
      else
      begin
         bank_mask_reg <= bank_mask_next;
         seg_mask_reg  <= seg_mask_next;
      end
   end

   // internal refresh sweep while in self refresh
   logic [15:0] ref_tmr_reg, ref_tmr_next;
   logic [5:0]  sweep_reg, sweep_next;
   logic        rp_reg, rp_next;
   logic [2:0]  rb_reg, rb_next, rs_reg, rs_next;
   logic [2:0]  sw_bank, sw_seg;
   logic        bank_live, seg_live;

   assign sw_bank   = sweep_reg[5:3];
   assign sw_seg    = sweep_reg[2:0];
   assign bank_live = !bank_mask_reg[sw_bank] && 32'(sw_bank) < NUM_BANKS; // RULE9 RULE13
   assign seg_live  = !(SEG_EN && seg_mask_reg[sw_seg]); // RULE10 RULE12 RULE13

   always_comb
   begin
      ref_tmr_next = ref_tmr_reg;
      sweep_next   = sweep_reg;
      rp_next      = 1'b0;
      rb_next      = rb_reg;
      rs_next      = rs_reg;
      // no new step in the exit cycle, pulses stay inside self refresh
      if (state_reg != ST_SREF || exit_now)
         ref_tmr_next = 16'h0; // RULE24
      else if (ref_tmr_reg != 16'h0)
         ref_tmr_next = ref_tmr_reg - 16'h1;
      else
      begin
         ref_tmr_next = 16'(REF_STEP_CYCLES - 1);
         sweep_next   = 6'(sweep_reg + 6'h1);
         if (bank_live && seg_live)
         begin
            rp_next = 1'b1; // RULE12
            rb_next = sw_bank;
            rs_next = sw_seg;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         ref_tmr_reg <= 16'h0;
         sweep_reg   <= 6'h0;
         rp_reg      <= 1'b0;
         rb_reg      <= 3'h0;
         rs_reg      <= 3'h0;
      end
      else
      begin
         ref_tmr_reg <= ref_tmr_next;
         sweep_reg   <= sweep_next;
         rp_reg      <= rp_next;
         rb_reg      <= rb_next;
         rs_reg      <= rs_next;
      end
   end

   // temperature status
   logic [2:0] temp_status;

   lpsr_temp_sensor #(
      .INTERVAL_CYCLES (TSI_CYCLES_P)
   ) u_temp (
      .core_clk     (core_clk),
      .rst_n        (rst_n),
      .sensor_code  (sensor_code),
      .force_update (exit_now),
      .temp_status  (temp_status)
   );

   // mode register read: capture, queue, launch after latency
   logic               gap_reg, gap_next, mrr_accept;
   logic [ENTRY_W-1:0] entry, head, hold_reg, hold_next;
   logic               f_ready, f_valid, pop;
   logic [LW-1:0]      launch_reg, launch_next;
   logic               second_reg, second_next, oe_reg, oe_next;
   logic [31:0]        dqr_reg, dqr_next, dqf_reg, dqf_next;

   assign mrr_accept = is_mrr && cmd_ok && !gap_reg && f_ready; // RULE17 RULE21

   always_comb
   begin
      entry = {2'(KIND_REG), 8'h00};
      case (cmd_addr)
         MA_TEMP:     entry = {2'(KIND_REG), 5'h00, temp_status}; // RULE22
         MA_CAL_A:    entry = {2'(KIND_CAL_A), 8'h00};
         MA_CAL_B:    entry = {2'(KIND_CAL_B), 8'h00};
         default:     entry = {2'(KIND_REG), 8'h00};
      endcase
   end

   lpsr_fifo #(
      .WIDTH (ENTRY_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .in_valid  (mrr_accept),
      .in_ready  (f_ready),
      .in_data   (entry),
      .out_valid (f_valid),
      .out_ready (pop),
      .out_data  (head)
   );

   assign pop = launch_reg[LW-1] && f_valid;

   always_comb
   begin
      gap_next    = mrr_accept && T_MRR_CYCLES > 1; // RULE17
      launch_next = {launch_reg[LW-2:0], mrr_accept};
      hold_next   = hold_reg;
      second_next = 1'b0;
      oe_next     = 1'b0;
      dqr_next    = 32'h0;
      dqf_next    = 32'h0;
      if (pop)
      begin
         hold_next   = head;
         second_next = 1'b1;
         oe_next     = 1'b1; // RULE16
         dqr_next    = beat_word(head, 0); // RULE15
         dqf_next    = beat_word(head, 1);
      end
      else if (second_reg)
      begin
         oe_next  = 1'b1; // RULE16 RULE17
         dqr_next = beat_word(hold_reg, 2);
         dqf_next = beat_word(hold_reg, 3);
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         gap_reg    <= 1'b0;
         launch_reg <= '0;
         hold_reg   <= '0;
         second_reg <= 1'b0;
         oe_reg     <= 1'b0;
         dqr_reg    <= 32'h0;
         dqf_reg    <= 32'h0;
      end
      else
      begin
         gap_reg    <= gap_next;
         launch_reg <= launch_next;
         hold_reg   <= hold_next;
         second_reg <= second_next;
         oe_reg     <= oe_next;
         dqr_reg    <= dqr_next;
         dqf_reg    <= dqf_next;
      end
   end

   assign dq_rise             = dqr_reg;
   assign dq_fall             = dqf_reg;
   assign dq_oe               = oe_reg;
   assign dqs_oe              = oe_reg;
   assign mrr_ready           = f_ready;
   assign self_refresh_active = sr_out_reg;
   assign xsr_busy            = xsr_out_reg;
   assign refresh_pulse       = rp_reg;
   assign refresh_bank        = rb_reg;
   assign refresh_segment     = rs_reg;
endmodule // lpsr_device

// [lpsr_device_props.sv]
// checker for read bursts, refresh masking and exit timing
`timescale 1ns/1ps
module lpsr_device_props
   import lpsr_pkg::*;
#(
   parameter int RL = 3
) (
   input wire logic       core_clk,
   input wire logic       rst_n,
   input wire logic       cke,
   input wire logic       cs_n,
   input wire logic [9:0] ca_rise,
   input wire logic [9:0] ca_fall,
   input wire logic       dq_oe,
   input wire logic       dqs_oe,
   input wire logic       self_refresh_active,
   input wire logic       xsr_busy,
   input wire logic       refresh_pulse,
   input wire logic [2:0] refresh_bank,
   input wire logic [2:0] refresh_segment
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic [7:0] bm_reg, bm_next, sm_reg, sm_next, ma;
   logic       mrr_cmd, mrw_hit;
   assign mrr_cmd = cke && !cs_n && ca_rise[3:0] == CMD_MRR;
   assign mrw_hit = cke && !cs_n && ca_rise[3:0] == CMD_MRW && !self_refresh_active && !xsr_busy;
   assign ma      = {ca_fall[1:0], ca_rise[9:4]};
   // shadow copy of both masks
   always_comb
   begin
      bm_next = bm_reg;
      sm_next = sm_reg;
      if (mrw_hit && ma == MA_BANK_MASK)
         bm_next = ca_fall[9:2];
      if (mrw_hit && ma == MA_SEG_MASK)
         sm_next = ca_fall[9:2];
   end
   always_ff @(posedge core_clk)
   begin
      bm_reg <= rst_n ? bm_next : MASK_RESET;
      sm_reg <= rst_n ? sm_next : MASK_RESET;
   end
   property p_oe_cause;
      $rose(dq_oe) |-> $past(mrr_cmd, RL);
   endproperty
   a_oe_cause: assert property (p_oe_cause) else $error("burst without read");
   property p_strobe;
      dqs_oe == dq_oe;
   endproperty
   a_strobe: assert property (p_strobe) else $error("strobe not with data");
   property p_burst;
      $rose(dq_oe) |-> dq_oe[*2];
   endproperty
   a_burst: assert property (p_burst) else $error("read burst cut short");
   property p_mask;
      refresh_pulse |-> !bm_reg[refresh_bank] && !sm_reg[refresh_segment];
   endproperty
   a_mask: assert property (p_mask) else $error("masked place refreshed");
   property p_pulse_sr;
      refresh_pulse |-> self_refresh_active;
   endproperty
   a_pulse_sr: assert property (p_pulse_sr) else $error("refresh outside self refresh");
   property p_xsr_len;
      $fell(self_refresh_active) |-> xsr_busy[*4] ##1 !xsr_busy;
   endproperty
   a_xsr_len: assert property (p_xsr_len) else $error("exit interval length wrong");
   property p_xsr_start;
      $rose(xsr_busy) |-> $past(cke) && $past(self_refresh_active);
   endproperty
   a_xsr_start: assert property (p_xsr_start) else $error("exit without cke high");
   property p_ckesr;
      $rose(self_refresh_active) |=> self_refresh_active;
   endproperty
   a_ckesr: assert property (p_ckesr) else $error("self refresh too short");
   c_burst: cover property ($rose(dq_oe));
   c_refresh: cover property (refresh_pulse);
   c_exit: cover property ($fell(xsr_busy));
endmodule // lpsr_device_props

bind lpsr_device lpsr_device_props #(.RL(RL)) u_props (
   .core_clk(core_clk),
   .rst_n(rst_n),
   .cke(cke),
   .cs_n(cs_n),
   .ca_rise(ca_rise),
   .ca_fall(ca_fall),
   .dq_oe(dq_oe),
   .dqs_oe(dqs_oe),
   .self_refresh_active(self_refresh_active),
   .xsr_busy(xsr_busy),
   .refresh_pulse(refresh_pulse),
   .refresh_bank(refresh_bank),
   .refresh_segment(refresh_segment)
);

// [lpsr_device_tb.sv]
// self-checking bench for the device block
`timescale 1ns/1ps
module lpsr_device_tb;
   import lpsr_pkg::*;
   localparam int RL = 3;
   logic        core_clk, rst_n, cke, cs_n;
   logic [9:0]  ca_rise, ca_fall;
   logic [2:0]  sensor_code, refresh_bank, refresh_segment;
   logic [31:0] dq_rise, dq_fall;
   logic        dq_oe, dqs_oe, mrr_ready, self_refresh_active, xsr_busy, refresh_pulse;
   logic [63:0] seen;
   int          bad_count, total_checks, cycles, cnt;

   lpsr_ctrl_model #(.RL(RL)) u_ctrl (.core_clk(core_clk), .cke(cke), .cs_n(cs_n),
      .ca_rise(ca_rise), .ca_fall(ca_fall));
   lpsr_device #(.RL(RL), .DENSITY_MBIT(1024), .REF_STEP_CYCLES(2), .TSI_CYCLES_P(5000)) u_dut (
      .core_clk(core_clk), .rst_n(rst_n), .cke(cke), .cs_n(cs_n),
      .ca_rise(ca_rise), .ca_fall(ca_fall), .sensor_code(sensor_code),
      .dq_rise(dq_rise), .dq_fall(dq_fall), .dq_oe(dq_oe), .dqs_oe(dqs_oe),
      .mrr_ready(mrr_ready), .self_refresh_active(self_refresh_active),
      .xsr_busy(xsr_busy), .refresh_pulse(refresh_pulse),
      .refresh_bank(refresh_bank), .refresh_segment(refresh_segment));

   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      cycles++;
      if (refresh_pulse === 1'b1)
         seen[{refresh_bank, refresh_segment}] <= 1'b1;
      if (cycles == 3000)
      begin
         bad_count++;
         summarize();
      end
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic read_expect(input logic [7:0] a, input logic [31:0] r0, f0, r1, f1);
      u_ctrl.mrr(a);
      repeat (RL - 1) @(posedge core_clk);
      @(negedge core_clk);
      check(dq_oe, 1, "burst start");
      check(dqs_oe, 1, "strobes");
      check(dq_rise, r0, "beat0");
      check(dq_fall, f0, "beat1");
      @(negedge core_clk);
      check(dqs_oe, 1, "strobes");
      check(dq_rise, r1, "beat2");
      check(dq_fall, f1, "beat3");
      @(negedge core_clk);
      check(dq_oe, 0, "burst end");
   endtask

   task automatic t_reset();
      @(negedge core_clk);
      check({dq_oe, self_refresh_active, xsr_busy, refresh_pulse}, 0, "reset outputs");
      repeat (2) @(negedge core_clk);
      check(mrr_ready, 1, "ready after reset");
   endtask
   task automatic t_regs();
      read_expect(MA_TEMP, 32'h5, 0, 0, 0);
      read_expect(MA_CAL_A, 32'hFFFFFFFF, 0, 32'hFFFFFFFF, 0);
      read_expect(MA_CAL_B, 0, 0, 32'hFFFFFFFF, 32'hFFFFFFFF);
      u_ctrl.mrw(MA_BANK_MASK, 8'h82);
      u_ctrl.mrw(MA_SEG_MASK, 8'h84);
      read_expect(MA_BANK_MASK, 0, 0, 0, 0);
   endtask
   task automatic t_partial_array_self_refresh();
      seen = '0;
      sensor_code = 3'h6;
      u_ctrl.sref();
      u_ctrl.nop(160);
      check(self_refresh_active, 1, "in self refresh");
      for (int i = 0; i < 64; i++)
         check(seen[i], !(i / 8 == 1 || i / 8 == 7 || i % 8 == 2 || i % 8 == 7), "map");
      u_ctrl.wake();
      cnt = 0;
      for (int i = 0; i < 10; i++)
      begin
         u_ctrl.nop(1);
         if (xsr_busy === 1'b1)
            cnt++;
      end
      check(cnt, XSR_CYCLES, "exit interval");
      check(self_refresh_active, 0, "left self refresh");
      u_ctrl.refresh_all();
      read_expect(MA_TEMP, 32'h6, 0, 0, 0);
   endtask

   initial
   begin
      rst_n = 1'b0;
      sensor_code = 3'h5;
      seen = '0;
      repeat (12) @(negedge core_clk);
      rst_n = 1'b1;
      t_reset();
      t_regs();
      t_partial_array_self_refresh();
      summarize();
   end
endmodule // lpsr_device_tb

// [lpsr_fifo.sv]
// small synchronous fifo with registered ready and valid
`timescale 1ns/1ps
module lpsr_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 16
) (
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
   logic [AW:0]      cnt_reg, cnt_next;
   logic             ready_reg, ready_next, valid_reg, valid_next, push, pop;

   always_comb
   begin
      push       = in_valid && ready_reg;
      pop        = out_ready && valid_reg;
      wr_next    = push ? AW'(wr_reg + 1'b1) : wr_reg;
      rd_next    = pop ? AW'(rd_reg + 1'b1) : rd_reg;
      cnt_next   = (AW+1)'(cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
      ready_next = cnt_next != (AW+1)'(DEPTH);
      valid_next = cnt_next != '0;
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         wr_reg    <= '0;
         rd_reg    <= '0;
         cnt_reg   <= '0;
         ready_reg <= 1'b0;
         valid_reg <= 1'b0;
      end
      else
      begin
         wr_reg    <= wr_next;
         rd_reg    <= rd_next;
         cnt_reg   <= cnt_next;
         ready_reg <= ready_next;
         valid_reg <= valid_next;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (push)
         mem_reg[wr_reg] <= in_data;
   end

   assign in_ready  = ready_reg;
   assign out_valid = valid_reg;
   assign out_data  = mem_reg[rd_reg];
endmodule // lpsr_fifo

// [lpsr_pkg.sv]
// constants shared by the self refresh, masking and mode register read logic
// What this block does
// RULE1 - controller restarts clock before self refresh exit
// RULE2 - controller waits exit interval before commands
// RULE3 - controller holds CKE high, NOPs during exit
// RULE4 - controller refreshes once between self refreshes
// RULE5 - two stable clocks before CKE rises
// RULE6 - all banks idle before self refresh entry
// RULE7 - exit interval starts edge after CKE high
// RULE8 - eight-bit bank mask written by register write
// RULE9 - masked bank gets no self refresh
// RULE10 - unmasked bank refreshes only unmasked segments
// RULE11 - eight segments from 1Gb, none below
// RULE12 - segment bit applies across all banks
// RULE13 - mask bit one blocks, zero refreshes
// RULE14 - register read decode and address fields
// RULE15 - register value on DQ[7:0] first beat
// RULE16 - all strobes toggle during read burst
// RULE17 - burst four, two-cycle period, uninterrupted
// RULE18 - controller sends only NOPs during period
// RULE19 - controller spacing from read to writes
// RULE20 - controller spacing from READ/WRITE to read
// RULE21 - register read never truncates data bursts
// RULE22 - temperature status fresh on self refresh exit
// RULE23 - temperature status updated every 32 ms
// RULE24 - refresh and minimum stay within tCKESR
// RULE25 - controller uses programmable spacing counters
package lpsr_pkg;
   localparam int          CLK_PERIOD_NS   = 40;
   localparam int          T_XSR_NS        = 140;
   localparam int          XSR_CYCLES      = (T_XSR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          T_CKESR_NS      = 15;
   localparam int          CKESR_CYCLES    = (T_CKESR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          T_TSI_MS        = 32;
   localparam int          TSI_CYCLES      = T_TSI_MS * 1000000 / CLK_PERIOD_NS;
   localparam int          T_MRR_CYCLES    = 2;
   localparam int          SEG_MIN_MBIT    = 1024;
   localparam int          FIFO_DEPTH      = 16;
   localparam int          ENTRY_W         = 10;
   localparam logic [3:0]  CMD_MRR         = 4'h8;
   localparam logic [3:0]  CMD_MRW         = 4'h0;
   localparam logic [2:0]  CMD_SREF        = 3'h4;
   localparam logic [7:0]  MA_TEMP         = 8'h04;
   localparam logic [7:0]  MA_BANK_MASK    = 8'h10;
   localparam logic [7:0]  MA_SEG_MASK     = 8'h11;
   localparam logic [7:0]  MA_CAL_A        = 8'h20;
   localparam logic [7:0]  MA_CAL_B        = 8'h28;
   localparam logic [3:0]  CAL_A_BEATS     = 4'h5;
   localparam logic [3:0]  CAL_B_BEATS     = 4'hC;
   localparam logic [7:0]  MASK_RESET      = 8'h00;
   localparam logic [2:0]  TEMP_RESET      = 3'h3;
   typedef enum logic [1:0] {KIND_REG, KIND_CAL_A, KIND_CAL_B} lpsr_kind_t;
endpackage

// [lpsr_temp_sensor.sv]
// periodic temperature status capture with forced refresh on exit
`timescale 1ns/1ps
module lpsr_temp_sensor
   import lpsr_pkg::*;
#(
   parameter int INTERVAL_CYCLES = TSI_CYCLES
) (
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic [2:0] sensor_code,
   input  wire logic       force_update,
   output logic      [2:0] temp_status
);
   logic [31:0] tmr_reg, tmr_next;
   logic [2:0]  stat_reg, stat_next;

   always_comb
   begin
      tmr_next  = tmr_reg - 32'h1;
      stat_next = stat_reg;
      if (force_update || tmr_reg == 32'h0)
      begin
         tmr_next  = 32'(INTERVAL_CYCLES - 1); // RULE23
         stat_next = sensor_code; // RULE22
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         tmr_reg  <= 32'h0;
         stat_reg <= TEMP_RESET;
      end
      else
      begin
         tmr_reg  <= tmr_next;
         stat_reg <= stat_next;
      end
   end

   assign temp_status = stat_reg;
endmodule // lpsr_temp_sensor
